// ===== core/ras_pkg.sv
// package: constants and carrier types for the return-address stack block
package ras_pkg;
  localparam int PC_W             = 21;          // program counter width
  localparam int SP_W             = 5;           // stack pointer width
  localparam int STACK_DEPTH      = 31;          // usable stack entries
  localparam logic [20:0] RESET_VECTOR  = 21'h000000;
  localparam logic [20:0] HI_PRIO_VECTOR = 21'h000008;
  localparam logic [20:0] LO_PRIO_VECTOR = 21'h000018;
  localparam logic [20:0] PC_STEP       = 21'h000002; // next sequential instruction
  localparam logic [20:0] MEM_BYTES_BIG   = 21'h008000; // 32 kbyte variant
  localparam logic [20:0] MEM_BYTES_SMALL = 21'h004000; // 16 kbyte variant, 8192 words
  localparam logic [15:0] NOP_WORD      = 16'h0000;
  localparam logic [4:0]  SP_RESET      = 5'h00;
  localparam logic [4:0]  SP_TOP        = 5'h1f;   // 31
  // apb register byte offsets
  localparam logic [11:0] OFS_PTR  = 12'h000;      // flags and pointer
  localparam logic [11:0] OFS_TOPL = 12'h004;
  localparam logic [11:0] OFS_TOPH = 12'h008;
  localparam logic [11:0] OFS_TOPU = 12'h00c;
  localparam logic [11:0] OFS_CFG  = 12'h010;      // overflow-reset enable, pc latches
  localparam logic [11:0] OFS_PC   = 12'h014;      // read-only current pc
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT  = 6;
  // one stack request from the sequencer
  typedef struct packed {
    logic        push;     // push, call, relative call, interrupt ack
    logic        pop;      // return, return-with-literal, return-from-interrupt
    logic        irq;      // interrupt ack: load vector; a wake comes in on i_wake_irq instead
    logic        irq_hi;   // interrupt is high priority
    logic [20:0] pc;       // pc to push
  } stack_req_type;
endpackage

// ===== core/ras_mem.sv
// file: 31 x 21 storage array for the return stack
`timescale 1ns/1ps
module ras_mem
  import ras_pkg::*;
#(
  parameter int DEPTH = 31,
  parameter int WIDTH = 21
) (
  // clock
  input  wire logic             i_clk,
  // write port
  input  wire logic             i_we,
  input  wire logic [4:0]       i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // read port, combinational
  input  wire logic [4:0]       i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);
  // entry index is pointer-1: pointer value zero has no storage
  logic [WIDTH-1:0] mem [DEPTH];

  // write; pointer zero is ignored
  always_ff @(posedge i_clk) begin
    if (i_we && i_waddr != 5'h00) begin
      mem[i_waddr - 5'h01] <= i_wdata;
    end
  end

  // read returns zero at pointer zero, which is how underflow yields pc 0
  always_comb begin
    if (i_raddr == 5'h00) begin
      o_rdata = '0;
    end else begin
      o_rdata = mem[i_raddr - 5'h01];
    end
  end
endmodule

// ===== core/return_address_stack.sv
// file: return-address stack, pc space decode and apb register slave
`timescale 1ns/1ps
// What this block and its software do
// RULE1: program counter is 21 bits wide
// RULE2: reset at 0000h, vectors 0008h and 0018h
// RULE3: fetch above implemented memory returns zeros
// RULE4: implemented memory 32 kbyte or 16 kbyte
// RULE5: up to 31 calls and interrupts stacked
// RULE6: push on push, calls, interrupt ack
// RULE7: pop on returns; latches left unchanged
// RULE8: 31 entries of 21 bits, 5-bit pointer
// RULE9: reset clears pointer; zero has no entry
// RULE10: push increments pointer, then writes entry
// RULE11: pop reads entry, then decrements pointer
// RULE12: pointer and top entry software accessible
// RULE13: flags show stack full or beyond
// RULE14: three byte registers access top entry
// RULE15: software masks interrupts while editing top
// RULE16: interrupt wake loads vector when enabled
// RULE17: interrupt wake pushes pc, advances pointer
// RULE18: overflow reset: push pc+2, flag, reset
// RULE19: no overflow reset: overwrite entry 31
// RULE20: empty pop returns zero, sets underflow
// RULE21: flags clear only by software or power-on
// RULE22: high priority to 0008h, low to 0018h
module return_address_stack
  import ras_pkg::*;
#(
  parameter logic SMALL_VARIANT = 1'b0   // 1: 16 kbyte memory
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_por,            // power-on reset pulse, clears flags
  // sequencer requests
  input  wire stack_req_type i_req,
  input  wire logic          i_wake_irq,       // wake from sleep by interrupt
  input  wire logic          i_irq_enable_hi,  // global_irq_enable_high
  input  wire logic          i_irq_enable_lo,  // global_irq_enable_low
  input  wire logic [20:0]   i_fetch_addr,     // program fetch address
  input  wire logic [15:0]   i_fetch_raw,      // raw word from program memory
  // pc and latch outputs
  output logic      [20:0]   o_pc,
  output logic               o_pc_load,        // pulse: pc loaded by pop or vector
  output logic      [15:0]   o_fetch_word,
  output logic               o_overflow_reset, // pulse: request device reset
  output logic      [7:0]    o_pc_upper_latch,
  output logic      [7:0]    o_pc_high_latch,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr
);
  // state registers, each written by a process below; the two sticky flags share one
  logic [4:0]  return_stack_pointer_ff;   // current top pointer
  logic        stack_full_flag_ff;        // sticky full
  logic        stack_underflow_flag_ff;   // sticky underflow
  logic        stack_overflow_reset_enable_ff; // overflow causes reset
  logic [20:0] pc_ff;                     // program counter copy
  logic        pc_load_ff;
  logic        ovf_rst_ff;
  logic [15:0] fetch_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  upper_latch_ff;
  logic [7:0]  high_latch_ff;
  // combinational helpers between the sequencer, the bus and storage
  logic [20:0] top_entry;                 // storage at pointer
  logic        mem_we;
  logic [20:0] mem_wdata;
  logic [4:0]  mem_waddr;
  logic [4:0]  nxt_sp;
  logic        do_push;
  logic        do_pop;
  logic        wake_push;
  logic        apb_wr;
  logic        apb_rd;
  logic        sw_write_top;

  // decode of a mapped apb offset, used by the error path
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == OFS_PTR) || (a == OFS_TOPL) || (a == OFS_TOPH) ||
             (a == OFS_TOPU) || (a == OFS_CFG) || (a == OFS_PC);
  endfunction

  // byte lane of the top entry selected by an offset
  function automatic logic [20:0] merge_byte(input logic [20:0] cur,
                                             input logic [11:0] a,
                                             input logic [7:0] b);
    logic [20:0] r;
    r = cur;
    if (a == OFS_TOPL) begin
      r[7:0] = b;
    end else if (a == OFS_TOPH) begin
      r[15:8] = b;
    end else if (a == OFS_TOPU) begin
      r[20:16] = b[4:0];
    end
    merge_byte = r;
  endfunction

  // wake by interrupt acts as an acknowledge only if an enable is set
  assign wake_push = i_wake_irq && (i_irq_enable_hi || i_irq_enable_lo); // RULE16
  assign do_push   = i_req.push || wake_push;       // RULE6 RULE17
  assign do_pop    = i_req.pop && !do_push;         // push wins a clash
  assign apb_wr    = psel && penable && pwrite && pready_ff;
  assign apb_rd    = psel && penable && !pwrite && pready_ff;
  assign sw_write_top = apb_wr && (paddr == OFS_TOPL || paddr == OFS_TOPH ||
                                   paddr == OFS_TOPU);

  // stack storage, entry addressed by pointer; pointer zero has none
  ras_mem #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_mem ( // RULE8 RULE12
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (return_stack_pointer_ff),
    .o_rdata (top_entry)
  );

  // next pointer: increment before write, decrement after read
  always_comb begin
    nxt_sp = return_stack_pointer_ff;
    if (do_push) begin
      if (return_stack_pointer_ff != SP_TOP) begin
        nxt_sp = return_stack_pointer_ff + 5'h01;   // RULE10 RULE5
      end
    end else if (do_pop) begin
      if (return_stack_pointer_ff != SP_RESET) begin
        nxt_sp = return_stack_pointer_ff - 5'h01;   // RULE11
      end
    end
  end

  // storage write: a push writes at the new pointer, software edits in place
  // a push and a software top edit in one cycle: the push wins and the edit
  // is lost, which is why software masks interrupts while editing the top
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = return_stack_pointer_ff;
    mem_wdata = top_entry;
    if (do_push) begin
      mem_we    = 1'b1;
      mem_waddr = nxt_sp;                            // RULE10 RULE19
      if (stack_overflow_reset_enable_ff && nxt_sp == SP_TOP &&
          return_stack_pointer_ff != SP_TOP) begin
        mem_wdata = i_req.pc + PC_STEP;              // RULE18
      end else begin
        mem_wdata = i_req.pc;                        // RULE17
      end
    end else if (sw_write_top) begin
      mem_we    = 1'b1;                              // RULE14
      mem_wdata = merge_byte(top_entry, paddr, pwdata[7:0]);
    end
  end

  // pointer register: overflow reset returns it to zero
  // a pointer write that meets a push or pop is dropped; the sequencer wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || ovf_rst_ff) begin
      return_stack_pointer_ff <= SP_RESET;           // RULE9 RULE18
    end else if (do_push || do_pop) begin
      return_stack_pointer_ff <= nxt_sp;
    end else if (apb_wr && paddr == OFS_PTR) begin
      return_stack_pointer_ff <= pwdata[4:0];        // RULE12
    end
  end

  // sticky flags survive ordinary resets; only power-on or software clear
  // writing 1 to a flag bit leaves it alone, writing 0 clears it
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      stack_full_flag_ff      <= 1'b0;               // RULE21
      stack_underflow_flag_ff <= 1'b0;
    end else begin
      // set wins over a software clear in the same cycle
      if (do_push && nxt_sp == SP_TOP) begin
        stack_full_flag_ff <= 1'b1;                  // RULE13 RULE19
      end else if (apb_wr && paddr == OFS_PTR && !pwdata[FULL_BIT]) begin
        stack_full_flag_ff <= 1'b0;                  // RULE21
      end
      if (do_pop && return_stack_pointer_ff == SP_RESET) begin
        stack_underflow_flag_ff <= 1'b1;             // RULE20
      end else if (apb_wr && paddr == OFS_PTR && !pwdata[UNF_BIT]) begin
        stack_underflow_flag_ff <= 1'b0;             // RULE21
      end
    end
  end

  // overflow reset request, one cycle after the 31st push
  // the pulse restarts pointer and pc one edge later, like a device reset;
  // the flags are kept so software can see why the core restarted
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ovf_rst_ff <= 1'b0;
    end else begin
      ovf_rst_ff <= do_push && stack_overflow_reset_enable_ff &&
                    return_stack_pointer_ff == 5'h1e;  // RULE18
    end
  end

  // configuration: overflow reset enabled by default
  // default on, so a runaway call chain restarts the core instead of looping
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stack_overflow_reset_enable_ff <= 1'b1;
    end else if (apb_wr && paddr == OFS_CFG) begin
      stack_overflow_reset_enable_ff <= pwdata[0];
    end
  end

  // program counter: reset vector, interrupt vectors, popped values
  // a wake with an enable set is handled like an acknowledged interrupt:
  // the pc is pushed and the vector loaded on the same edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || ovf_rst_ff) begin
      pc_ff      <= RESET_VECTOR;                    // RULE2 RULE1
      pc_load_ff <= 1'b0;
    end else if (i_req.irq || wake_push) begin
      // vector taken in the same edge as the push, so push is done first
      pc_ff      <= i_req.irq_hi ? HI_PRIO_VECTOR : LO_PRIO_VECTOR; // RULE22 RULE16
      pc_load_ff <= 1'b1;
    end else if (do_pop) begin
      pc_ff      <= top_entry;                       // RULE11 RULE20
      pc_load_ff <= 1'b1;
    end else begin
      pc_ff      <= i_req.pc;
      pc_load_ff <= 1'b0;
    end
  end

  // pc latches are untouched by returns; only software writes them
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      upper_latch_ff <= 8'h00;
      high_latch_ff  <= 8'h00;
    end else if (apb_wr && paddr == OFS_CFG) begin
      upper_latch_ff <= {3'h0, pwdata[20:16]};       // RULE7
      high_latch_ff  <= pwdata[15:8];
    end
  end

  // fetch filter: beyond implemented memory reads as a no-op
  // the limit follows the variant; the rest of the 2 mbyte space is empty
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fetch_ff <= NOP_WORD;
    end else if (i_fetch_addr >= (SMALL_VARIANT ? MEM_BYTES_SMALL : MEM_BYTES_BIG)) begin
      fetch_ff <= NOP_WORD;                          // RULE3 RULE4
    end else begin
      fetch_ff <= i_fetch_raw;
    end
  end

  // apb: one wait state, ready after setup; unmapped gives slverr
  // setup edge is ignored, the first access edge arms pready, and the next
  // edge completes the transfer, which is where a write lands
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !mapped(paddr);
      prdata_ff  <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFS_PTR:  prdata_ff <= {24'h0, stack_full_flag_ff, stack_underflow_flag_ff,
                                  1'b0, return_stack_pointer_ff}; // RULE13
          OFS_TOPL: prdata_ff <= {24'h0, top_entry[7:0]};         // RULE14
          OFS_TOPH: prdata_ff <= {24'h0, top_entry[15:8]};
          OFS_TOPU: prdata_ff <= {27'h0, top_entry[20:16]};
          OFS_CFG:  prdata_ff <= {11'h0, upper_latch_ff[4:0], high_latch_ff,
                                  7'h0, stack_overflow_reset_enable_ff};
          OFS_PC:   prdata_ff <= {11'h0, pc_ff};
          default:  prdata_ff <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // every output comes straight from its register
  assign o_pc             = pc_ff;
  assign o_pc_load        = pc_load_ff;
  assign o_fetch_word     = fetch_ff;
  assign o_overflow_reset = ovf_rst_ff;
  assign o_pc_upper_latch = upper_latch_ff;
  assign o_pc_high_latch  = high_latch_ff;
  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  // apb_rd kept for clarity of the read path
  logic unused_rd;
  assign unused_rd = apb_rd;
endmodule

// ===== sim/ras_monitor.sv
// checker: port-level assertions for the return-address stack
`timescale 1ns/1ps
module ras_monitor
  import ras_pkg::*;
#(
  parameter logic SMALL_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic          i_clk,
  input wire logic          i_rst_n,
  // sequencer side
  input wire stack_req_type i_req,
  input wire logic          i_wake_irq,
  input wire logic          i_irq_enable_hi,
  input wire logic          i_irq_enable_lo,
  input wire logic [20:0]   i_fetch_addr,
  input wire logic [15:0]   i_fetch_raw,
  input wire logic [20:0]   o_pc,
  input wire logic          o_pc_load,
  input wire logic [15:0]   o_fetch_word,
  input wire logic          o_overflow_reset,
  input wire logic [7:0]    o_pc_upper_latch,
  input wire logic [7:0]    o_pc_high_latch,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic          pready,
  input wire logic          pslverr
);
  // first address with no memory behind it
  localparam logic [20:0] LIM = SMALL_VARIANT ? MEM_BYTES_SMALL : MEM_BYTES_BIG;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  fetch_zero_a: assert property (i_fetch_addr >= LIM |=> o_fetch_word == NOP_WORD)
    else $error("fetch above memory not zero");
  fetch_pass_a: assert property (i_fetch_addr < LIM |=> o_fetch_word == $past(i_fetch_raw))
    else $error("fetch word not passed");
  vec_high_a: assert property (i_req.irq && i_req.irq_hi |=> o_pc_load && o_pc == HI_PRIO_VECTOR)
    else $error("high vector wrong");
  vec_low_a: assert property (i_req.irq && !i_req.irq_hi |=> o_pc_load && o_pc == LO_PRIO_VECTOR)
    else $error("low vector wrong");
  wake_vec_a: assert property (i_wake_irq && (i_irq_enable_hi || i_irq_enable_lo) |=>
    o_pc_load && (o_pc == HI_PRIO_VECTOR || o_pc == LO_PRIO_VECTOR))
    else $error("wake did not vector");
  pop_load_a: assert property (i_req.pop && !i_req.push && !i_req.irq |=> o_pc_load)
    else $error("pop did not load pc");
  // a write to config is the only way the latches move; the check is also waived while an overflow reset pulses
  latch_hold_a: assert property (!(psel && pwrite && paddr == OFS_CFG) && !o_overflow_reset
    |=> $stable(o_pc_high_latch) && $stable(o_pc_upper_latch))
    else $error("pc latch changed");
  wait_state_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing");
  unmapped_a: assert property (psel && penable && !pready && paddr > OFS_PC |=> pslverr)
    else $error("unmapped access not refused");
  ovf_pulse_a: assert property ($rose(o_overflow_reset) |=> $fell(o_overflow_reset))
    else $error("overflow reset not a pulse");
  cover property (i_req.irq && i_req.irq_hi);
  cover property (o_overflow_reset);
  cover property (pslverr && pready);
  cover property (i_wake_irq && i_irq_enable_lo);
endmodule

bind return_address_stack ras_monitor #(.SMALL_VARIANT(SMALL_VARIANT)) ras_monitor_i (.*);

// ===== sim/seq_model.sv
// partner model: instruction sequencer issuing stack requests
`timescale 1ns/1ps
module seq_model
  import ras_pkg::*;
(
  // clock
  input  wire logic     i_clk,
  // requests to the stack
  output stack_req_type o_req,
  output logic          o_wake_irq,
  output logic          o_irq_enable_hi,
  output logic          o_irq_enable_lo
);
  // idle at time zero; enables low so software top edits stay undisturbed
  initial begin
    o_req = '0;
    o_wake_irq = 1'b0;
    o_irq_enable_hi = 1'b0;
    o_irq_enable_lo = 1'b0;
  end
  // one request held for one cycle, then a cycle idle
  task automatic issue(input stack_req_type r, input logic wake);
    @(posedge i_clk);
    o_req <= r;
    o_wake_irq <= wake;
    o_irq_enable_hi <= wake && r.irq_hi;
    o_irq_enable_lo <= wake && !r.irq_hi;
    @(posedge i_clk);
    o_req <= '0;
    o_wake_irq <= 1'b0;
    o_irq_enable_hi <= 1'b0;
    o_irq_enable_lo <= 1'b0;
  endtask
  // call, interrupt ack, return and wake helpers
  task automatic push(input logic [20:0] pc);
    issue('{1'b1, 1'b0, 1'b0, 1'b0, pc}, 1'b0);
  endtask
  task automatic pop();
    issue('{1'b0, 1'b1, 1'b0, 1'b0, 21'h0}, 1'b0);
  endtask
  task automatic irq(input logic hi, input logic [20:0] pc);
    issue('{1'b1, 1'b0, 1'b1, hi, pc}, 1'b0);
  endtask
  task automatic wake(input logic hi, input logic [20:0] pc);
    issue('{1'b0, 1'b0, 1'b0, hi, pc}, 1'b1);
  endtask
endmodule

// ===== sim/return_address_stack_bench.sv
// testbench: sequencer, apb and fetch scenarios for the return-address stack
`timescale 1ns/1ps
module return_address_stack_bench;
  import ras_pkg::*;
  logic          i_clk, i_rst_n, i_por, psel, penable, pwrite, pready, pslverr;
  logic          pc_load, ovf, wake, en_hi, en_lo, err;
  stack_req_type req;
  logic [20:0]   fetch_addr, pc;
  logic [15:0]   fetch_raw, fetch_word;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [7:0]    lat_u, lat_h;
  int            err_count, n_compared;
  // free-running 10 MHz clock
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;
  return_address_stack return_address_stack_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_por(i_por),
    .i_req(req), .i_wake_irq(wake), .i_irq_enable_hi(en_hi), .i_irq_enable_lo(en_lo),
    .i_fetch_addr(fetch_addr), .i_fetch_raw(fetch_raw), .o_pc(pc), .o_pc_load(pc_load),
    .o_fetch_word(fetch_word), .o_overflow_reset(ovf), .o_pc_upper_latch(lat_u),
    .o_pc_high_latch(lat_h), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  seq_model seq_model_i (.i_clk(i_clk), .o_req(req), .o_wake_irq(wake),
    .o_irq_enable_hi(en_hi), .o_irq_enable_lo(en_lo));
  // one compare for every result kind, widened to a word
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer: setup, access, hold until pready sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // pc is settled by the falling edge after the pop or vector
  task automatic pc_chk(input logic [20:0] exp);
    @(negedge i_clk);
    chk("o_pc", {11'h0, exp}, {11'h0, pc});
  endtask
  task automatic t_reset_state();
    rdchk("ptr", OFS_PTR, 32'h0);
    rdchk("pc", OFS_PC, 32'h0);
    rdchk("cfg", OFS_CFG, 32'h1);
  endtask
  // pop on empty, flags survive a plain reset, software clears them
  task automatic t_underflow();
    seq_model_i.pop();
    pc_chk(21'h0);
    rdchk("ptr", OFS_PTR, 32'h40);
    @(posedge i_clk) i_rst_n <= 1'b0;
    @(posedge i_clk) i_rst_n <= 1'b1;
    rdchk("ptr", OFS_PTR, 32'h40);
    apb(1'b1, OFS_PTR, 32'h0);
    rdchk("ptr", OFS_PTR, 32'h0);
  endtask
  // push order, top bytes, software edit, pops leave latches alone
  task automatic t_push_pop();
    apb(1'b1, OFS_CFG, 32'h05ab01);
    seq_model_i.push(21'h000100);
    seq_model_i.push(21'h012344);
    seq_model_i.push(21'h1ffffe);
    rdchk("ptr", OFS_PTR, 32'h3);
    rdchk("topl", OFS_TOPL, 32'hfe);
    rdchk("toph", OFS_TOPH, 32'hff);
    rdchk("topu", OFS_TOPU, 32'h1f);
    apb(1'b1, OFS_TOPL, 32'h10);
    apb(1'b1, OFS_TOPH, 32'h32);
    apb(1'b1, OFS_TOPU, 32'h04);
    seq_model_i.pop();
    pc_chk(21'h043210);
    chk("latches", 32'h05ab, {16'h0, lat_u, lat_h});
    seq_model_i.pop();
    pc_chk(21'h012344);
    seq_model_i.pop();
    pc_chk(21'h000100);
    rdchk("ptr", OFS_PTR, 32'h0);
  endtask
  // both priorities vector and push, then an interrupt wake
  task automatic t_irq();
    seq_model_i.irq(1'b1, 21'h000246);
    pc_chk(HI_PRIO_VECTOR);
    seq_model_i.irq(1'b0, 21'h000300);
    pc_chk(LO_PRIO_VECTOR);
    seq_model_i.wake(1'b0, 21'h000400);
    pc_chk(LO_PRIO_VECTOR);
    rdchk("ptr", OFS_PTR, 32'h3);
    rdchk("toph", OFS_TOPH, 32'h04);
    apb(1'b1, OFS_PTR, 32'h0);
  endtask
  // full stack with and without the overflow reset
  task automatic t_overflow();
    int n;
    apb(1'b1, OFS_CFG, 32'h0);
    for (n = 1; n <= STACK_DEPTH; n++) seq_model_i.push(21'(2 * n));
    rdchk("ptr", OFS_PTR, 32'h9f);
    seq_model_i.push(21'h000777);
    rdchk("ptr", OFS_PTR, 32'h9f);
    rdchk("topl", OFS_TOPL, 32'h77);
    apb(1'b1, OFS_PTR, 32'h0);
    apb(1'b1, OFS_CFG, 32'h1);
    for (n = 1; n <= STACK_DEPTH; n++) seq_model_i.push(21'(2 * n));
    n = 0;
    while (ovf !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      n++;
    end
    chk("ovf", 32'h1, {31'h0, ovf});
    repeat (3) @(posedge i_clk);
    rdchk("ptr", OFS_PTR, 32'h80);
    // the 31st entry holds that push's pc plus one instruction step
    apb(1'b1, OFS_PTR, 32'h9f);
    rdchk("topl", OFS_TOPL, 32'h40);
  endtask
  // fetch below, at and far above the end of memory
  task automatic t_fetch();
    logic [20:0] a[3] = '{21'h007ffe, MEM_BYTES_BIG, 21'h1ffffe};
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      fetch_addr <= a[i];
      fetch_raw <= 16'ha5c3;
      @(posedge i_clk);
      @(negedge i_clk);
      chk("fetch", (i == 0) ? 32'ha5c3 : 32'h0, {16'h0, fetch_word});
    end
  endtask
  task automatic t_unmapped();
    apb(1'b0, 12'h018, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("rdata", 32'h0, rd);
  endtask
  // verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence: reset with power-on, then every scenario
  initial begin
    {i_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {fetch_addr, fetch_raw} = '0;
    i_por = 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_por <= 1'b0;
    t_reset_state();
    t_underflow();
    t_push_pop();
    t_irq();
    t_overflow();
    t_fetch();
    t_unmapped();
    results();
  end
  // watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    results();
  end
endmodule
